// ---- verilog/phs_pkg.sv ----
// Shared constants for the controller host-side signalling block.
// Assumes a 20 MHz system clock and a host link clocked by the host master.
package phs_pkg;

    // System clock rate
    localparam int CLK_HZ = 20_000_000;
    // Fastest host link clock the target is built for
    localparam int LINK_MAX_HZ = 400_000;
    // Worst-case host link clock period in system clock cycles
    localparam int LINK_PERIOD_CYC = CLK_HZ / LINK_MAX_HZ;

    // Protocol message length in bytes
    localparam int MSG_BYTES = 15;
    localparam int MSG_W = MSG_BYTES * 8;
    localparam logic [3:0] MSG_LAST = 4'he;
    localparam logic [3:0] IDX_SAT = 4'hf;
    // Byte sent when the host reads past the reply
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    // Bit counter marks inside one byte
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_FULL = 4'h8;

    // Strap code that selects the serial port instead of the host link
    localparam logic [2:0] STRAP_UART = 3'h0;

    // Self-reset pulse on the reset pin
    localparam int SELF_RST_US = 100;
    localparam int SELF_RST_CYC = SELF_RST_US * (CLK_HZ / 1_000_000);
    localparam int RST_CNT_W = 11;
    localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = RST_CNT_W'(SELF_RST_CYC - 1);

    // Host link target states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_RX,
        ST_TX,
        ST_TACK
    } phs_link_st_t;

endpackage

// ---- verilog/phs_host_side.sv ----
// Host-side signalling of the power-sourcing controller: host link target,
// reply-pending line, event interrupt, port kill, fan, indicator strobes,
// health line and self-reset pin driver.
// Assumes pins are open drain with pull-ups outside; the message engine
// and the indicator stream sit on clk_i beside this block.
// Behaviour
// - Host link is an I2C target at up to 400 KHz; it may stretch the clock.
// - Every request and reply message is exactly 15 bytes.
// - Reply-pending goes low as soon as a reply is held.
// - Reply-pending returns high once the host has read the reply.
// - Event interrupt is low while any enabled event is in progress.
// - Port-disable input low switches off every power port.
// - Fan output is active high and requests cooling.
// - Indicator stream select output is active low.
// - Indicator stream latch output is active low.
// - Indicator stream output enable is active low.
// - Health output follows faults through a software-settable mask.
// - Sense level picks serial port or I2C, and the I2C target address.
// - Self-reset drives the reset pin low for about 100 us.
`timescale 1ns/1ps
module phs_host_side
    import phs_pkg::*;
#(
    parameter logic [6:0] ADDR_BASE = 7'h20,
    parameter int EVT_W = 8,
    parameter int HLT_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Host link clock pin, also the link capture clock
    input wire logic host_link_clock_i,
    output logic host_link_clock_o,
    output logic host_link_clock_oe_o,
    // Host link data pin
    input wire logic host_link_data_i,
    output logic host_link_data_o,
    output logic host_link_data_oe_o,
    // Link selection strap
    input wire logic [2:0] link_select_sense_i,
    output logic link_uart_mode_o,
    output logic [6:0] link_addr_o,
    // Received request bytes
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_msg_done_o,
    input wire logic link_busy_i,
    // Reply to the host
    input wire logic [MSG_W-1:0] reply_msg_i,
    input wire logic reply_load_i,
    output logic reply_pending_n_o,
    output logic reply_taken_o,
    // Event interrupt
    input wire logic [EVT_W-1:0] event_active_i,
    input wire logic [EVT_W-1:0] event_enable_i,
    output logic event_irq_n_o,
    // Port kill and fan
    input wire logic all_ports_off_n_i,
    output logic ports_shutdown_o,
    input wire logic cool_req_i,
    output logic fan_on_o,
    // Indicator stream strobes
    input wire logic ind_select_i,
    input wire logic ind_strobe_i,
    input wire logic ind_drive_i,
    output logic indicator_select_n_o,
    output logic indicator_strobe_n_o,
    output logic indicator_drive_en_n_o,
    // Health line
    input wire logic [HLT_W-1:0] health_fault_i,
    input wire logic [HLT_W-1:0] health_mask_i,
    output logic health_good_n_o,
    // Self-reset pin
    input wire logic self_reset_req_i,
    input wire logic ext_reset_n_i,
    output logic ext_reset_n_o,
    output logic ext_reset_n_oe_o,
    output logic ext_reset_busy_o
);

    // Byte idx of the stored reply, first byte in the top bits
    function automatic logic [7:0] byte_at(input logic [MSG_W-1:0] msg, input logic [3:0] idx);
        logic [7:0] b;
        b = IDLE_BYTE;
        if (idx <= MSG_LAST) begin
            b = msg[(MSG_BYTES - 1 - int'(idx)) * 8 +: 8];
        end
        return b;
    endfunction

    // Link-domain capture of the data line on each clock rise
    logic lk_bit_ff;
    always_ff @(posedge host_link_clock_i) begin
        lk_bit_ff <= host_link_data_i;
    end

    // Two-flop synchronisers for pins and the captured bit
    logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff, bit_s1_ff, bit_s2_ff;
    logic off_s1_ff, off_s2_ff, rst_s1_ff, rst_s2_ff;
    logic [2:0] sel_s1_ff, sel_s2_ff;
    logic scl_p_ff, sda_p_ff;
    always_ff @(posedge clk_i) begin
        scl_s1_ff <= host_link_clock_i;
        scl_s2_ff <= scl_s1_ff;
        sda_s1_ff <= host_link_data_i;
        sda_s2_ff <= sda_s1_ff;
        bit_s1_ff <= lk_bit_ff;
        bit_s2_ff <= bit_s1_ff;
        off_s1_ff <= all_ports_off_n_i;
        off_s2_ff <= off_s1_ff;
        rst_s1_ff <= ext_reset_n_i;
        rst_s2_ff <= rst_s1_ff;
        sel_s1_ff <= link_select_sense_i;
        sel_s2_ff <= sel_s1_ff;
        scl_p_ff <= scl_s2_ff;
        sda_p_ff <= sda_s2_ff;
    end

    // Bus conditions seen on the synchronised lines
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s2_ff & ~scl_p_ff;
    assign scl_fall = ~scl_s2_ff & scl_p_ff;
    assign bus_start = scl_s2_ff & scl_p_ff & sda_p_ff & ~sda_s2_ff;
    assign bus_stop = scl_s2_ff & scl_p_ff & ~sda_p_ff & sda_s2_ff;

    // Strap capture after reset release
    logic strap_done_ff, uart_ff, nxt_strap_done, nxt_uart;
    logic [6:0] addr_ff, nxt_addr;
    always_comb begin
        nxt_strap_done = 1'b1;
        nxt_uart = uart_ff;
        nxt_addr = addr_ff;
        if (!strap_done_ff) begin
            nxt_uart = (sel_s2_ff == STRAP_UART);
            nxt_addr = 7'(ADDR_BASE + {4'h0, sel_s2_ff});
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            strap_done_ff <= 1'b0;
            uart_ff <= 1'b1;
            addr_ff <= 7'h00;
        end else begin
            strap_done_ff <= nxt_strap_done;
            uart_ff <= nxt_uart;
            addr_ff <= nxt_addr;
        end
    end

    // Host link target state
    phs_link_st_t st_ff, nxt_st;
    logic [3:0] bits_ff, nxt_bits, rx_idx_ff, nxt_rx_idx, tx_idx_ff, nxt_tx_idx;
    logic [7:0] sh_ff, nxt_sh, rx_data_ff, nxt_rx_data, tx_byte;
    logic rw_ff, nxt_rw, ph_ff, nxt_ph, sda_low_ff, nxt_sda_low;
    logic stretch_ff, nxt_stretch, rx_valid_ff, nxt_rx_valid;
    logic rx_done_ff, nxt_rx_done, taken_ff, nxt_taken;
    logic [MSG_W-1:0] msg_ff, nxt_msg;
    logic pend_ff, nxt_pend;

    assign tx_byte = byte_at(msg_ff, tx_idx_ff);

    // Shift register only moves on a rise while collecting a byte
    function automatic logic rise_or_keep();
        return scl_rise && (st_ff == ST_ADDR || st_ff == ST_RX);
    endfunction

    // Next state of the target: address, ack, receive and send bytes
    always_comb begin
        nxt_st = st_ff;
        nxt_bits = bits_ff;
        nxt_sh = {sh_ff[6:0], bit_s2_ff};
        nxt_rw = rw_ff;
        nxt_ph = ph_ff;
        nxt_sda_low = sda_low_ff;
        nxt_stretch = stretch_ff & link_busy_i;
        nxt_rx_idx = rx_idx_ff;
        nxt_tx_idx = tx_idx_ff;
        nxt_rx_data = rx_data_ff;
        nxt_rx_valid = 1'b0;
        nxt_rx_done = 1'b0;
        nxt_taken = 1'b0;
        if (!rise_or_keep()) begin
            nxt_sh = sh_ff;
        end
        if (bus_start && !uart_ff) begin
            nxt_st = ST_ADDR;
            nxt_bits = 4'h0;
            nxt_sda_low = 1'b0;
            nxt_rx_idx = 4'h0;
            nxt_tx_idx = 4'h0;
        end else if (bus_stop) begin
            nxt_st = ST_IDLE;
            nxt_sda_low = 1'b0;
            nxt_stretch = 1'b0;
        end else begin
            unique case (st_ff)
                ST_IDLE: begin
                    nxt_sda_low = 1'b0;
                end
                ST_ADDR: if (scl_rise) begin
                    nxt_bits = bits_ff + 4'h1;
                    if (bits_ff == BIT_LAST) begin
                        nxt_rw = nxt_sh[0];
                        nxt_ph = 1'b0;
                        nxt_st = (nxt_sh[7:1] == addr_ff) ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: if (scl_fall) begin
                    if (!ph_ff) begin
                        nxt_sda_low = 1'b1;
                        nxt_ph = 1'b1;
                    end else begin
                        nxt_ph = 1'b0;
                        nxt_bits = 4'h0;
                        if (rw_ff) begin
                            nxt_st = ST_TX;
                            nxt_sda_low = ~tx_byte[7];
                        end else begin
                            nxt_st = ST_RX;
                            nxt_sda_low = 1'b0;
                            nxt_stretch = link_busy_i;
                        end
                    end
                end
                ST_RX: if (scl_rise) begin
                    nxt_bits = bits_ff + 4'h1;
                    if (bits_ff == BIT_LAST) begin
                        nxt_rx_data = nxt_sh;
                        nxt_rx_valid = 1'b1;
                        nxt_st = ST_ACK;
                        nxt_ph = 1'b0;
                        if (rx_idx_ff == MSG_LAST) begin
                            nxt_rx_done = 1'b1;
                            nxt_rx_idx = 4'h0;
                        end else begin
                            nxt_rx_idx = rx_idx_ff + 4'h1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        nxt_bits = bits_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (bits_ff == BIT_FULL) begin
                            nxt_sda_low = 1'b0;
                            nxt_st = ST_TACK;
                        end else begin
                            nxt_sda_low = ~tx_byte[3'h7 - bits_ff[2:0]];
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise) begin
                        nxt_ph = bit_s2_ff;
                        nxt_taken = (tx_idx_ff == MSG_LAST);
                        if (tx_idx_ff != IDX_SAT) begin
                            nxt_tx_idx = tx_idx_ff + 4'h1;
                        end
                    end else if (scl_fall) begin
                        nxt_bits = 4'h0;
                        nxt_ph = 1'b0;
                        nxt_st = ph_ff ? ST_IDLE : ST_TX;
                        nxt_sda_low = ph_ff ? 1'b0 : ~tx_byte[7];
                    end
                end
            endcase
        end
    end

    // Reply store and pending flag; a new reply wins over a clear
    always_comb begin
        nxt_msg = reply_load_i ? reply_msg_i : msg_ff;
        nxt_pend = (pend_ff & ~taken_ff) | reply_load_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_ff <= ST_IDLE;
            bits_ff <= 4'h0;
            sh_ff <= 8'h00;
            rw_ff <= 1'b0;
            ph_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            stretch_ff <= 1'b0;
            rx_idx_ff <= 4'h0;
            tx_idx_ff <= 4'h0;
            rx_data_ff <= 8'h00;
            rx_valid_ff <= 1'b0;
            rx_done_ff <= 1'b0;
            taken_ff <= 1'b0;
            msg_ff <= '0;
            pend_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            bits_ff <= nxt_bits;
            sh_ff <= nxt_sh;
            rw_ff <= nxt_rw;
            ph_ff <= nxt_ph;
            sda_low_ff <= nxt_sda_low;
            stretch_ff <= nxt_stretch;
            rx_idx_ff <= nxt_rx_idx;
            tx_idx_ff <= nxt_tx_idx;
            rx_data_ff <= nxt_rx_data;
            rx_valid_ff <= nxt_rx_valid;
            rx_done_ff <= nxt_rx_done;
            taken_ff <= nxt_taken;
            msg_ff <= nxt_msg;
            pend_ff <= nxt_pend;
        end
    end

    // Side-band outputs, registered
    logic irq_n_ff, kill_ff, fan_ff, sel_n_ff, stb_n_ff, oe_n_ff, good_n_ff;
    logic nxt_irq_n, nxt_kill, nxt_fan, nxt_sel_n, nxt_stb_n, nxt_oe_n, nxt_good_n;
    always_comb begin
        nxt_irq_n = ~|(event_active_i & event_enable_i);
        nxt_kill = ~off_s2_ff;
        nxt_fan = cool_req_i;
        nxt_sel_n = ~ind_select_i;
        nxt_stb_n = ~ind_strobe_i;
        nxt_oe_n = ~ind_drive_i;
        nxt_good_n = |(health_fault_i & health_mask_i);
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_n_ff <= 1'b1;
            kill_ff <= 1'b0;
            fan_ff <= 1'b0;
            sel_n_ff <= 1'b1;
            stb_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            good_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= nxt_irq_n;
            kill_ff <= nxt_kill;
            fan_ff <= nxt_fan;
            sel_n_ff <= nxt_sel_n;
            stb_n_ff <= nxt_stb_n;
            oe_n_ff <= nxt_oe_n;
            good_n_ff <= nxt_good_n;
        end
    end

    // Self-reset pulse on the reset pin, then wait for the pin to rise
    logic rdrv_ff, rwait_ff, nxt_rdrv, nxt_rwait;
    logic [RST_CNT_W-1:0] rcnt_ff, nxt_rcnt;
    always_comb begin
        nxt_rdrv = rdrv_ff;
        nxt_rwait = rwait_ff;
        nxt_rcnt = rcnt_ff;
        if (rdrv_ff) begin
            if (rcnt_ff == RST_CNT_LAST) begin
                nxt_rdrv = 1'b0;
                nxt_rwait = 1'b1;
            end else begin
                nxt_rcnt = rcnt_ff + 1'b1;
            end
        end else if (rwait_ff) begin
            nxt_rwait = ~rst_s2_ff;
        end else if (self_reset_req_i) begin
            nxt_rdrv = 1'b1;
            nxt_rcnt = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdrv_ff <= 1'b0;
            rwait_ff <= 1'b0;
            rcnt_ff <= '0;
        end else begin
            rdrv_ff <= nxt_rdrv;
            rwait_ff <= nxt_rwait;
            rcnt_ff <= nxt_rcnt;
        end
    end

    // Output drive
    assign host_link_clock_o = 1'b0;
    assign host_link_clock_oe_o = stretch_ff;
    assign host_link_data_o = 1'b0;
    assign host_link_data_oe_o = sda_low_ff;
    assign link_uart_mode_o = uart_ff;
    assign link_addr_o = addr_ff;
    assign rx_data_o = rx_data_ff;
    assign rx_valid_o = rx_valid_ff;
    assign rx_msg_done_o = rx_done_ff;
    assign reply_pending_n_o = ~pend_ff;
    assign reply_taken_o = taken_ff;
    assign event_irq_n_o = irq_n_ff;
    assign ports_shutdown_o = kill_ff;
    assign fan_on_o = fan_ff;
    assign indicator_select_n_o = sel_n_ff;
    assign indicator_strobe_n_o = stb_n_ff;
    assign indicator_drive_en_n_o = oe_n_ff;
    assign health_good_n_o = good_n_ff;
    assign ext_reset_n_o = 1'b0;
    assign ext_reset_n_oe_o = rdrv_ff;
    assign ext_reset_busy_o = rdrv_ff | rwait_ff;

    // Checks on the system clock
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_pend_on_load: assert property (reply_load_i |=> !reply_pending_n_o)
        else $error("reply pending not asserted after load");
    a_pend_release: assert property ($rose(reply_pending_n_o) |-> $past(reply_taken_o))
        else $error("reply pending released without full read");
    a_taken_last: assert property (reply_taken_o |-> $past(tx_idx_ff) == MSG_LAST)
        else $error("reply taken before last byte");
    a_msg_length: assert property (rx_msg_done_o |-> rx_valid_o && rx_idx_ff == 4'h0)
        else $error("message end not on fifteenth byte");
    a_irq_events: assert property ($past(rstn_i)
        |-> event_irq_n_o == !$past(|(event_active_i & event_enable_i)))
        else $error("interrupt line does not follow enabled events");
    a_ports_kill: assert property (!all_ports_off_n_i [*3] |=> ports_shutdown_o)
        else $error("ports not shut down while disable held");
    a_fan_level: assert property ($past(rstn_i) |-> fan_on_o == $past(cool_req_i))
        else $error("fan output does not follow cooling request");
    a_ind_select: assert property ($past(rstn_i)
        |-> indicator_select_n_o == !$past(ind_select_i))
        else $error("indicator select not active low");
    a_ind_strobe: assert property ($past(rstn_i)
        |-> indicator_strobe_n_o == !$past(ind_strobe_i))
        else $error("indicator latch not active low");
    a_ind_drive: assert property ($past(rstn_i)
        |-> indicator_drive_en_n_o == !$past(ind_drive_i))
        else $error("indicator enable not active low");
    a_health_mask: assert property ($past(rstn_i)
        |-> health_good_n_o == $past(|(health_fault_i & health_mask_i)))
        else $error("health line ignores mask");
    a_reset_len: assert property ($fell(ext_reset_n_oe_o) |-> $past(rcnt_ff) == RST_CNT_LAST)
        else $error("self reset pulse has wrong length");
    a_stretch_busy: assert property (host_link_clock_oe_o |-> $past(link_busy_i))
        else $error("clock held low without busy");
    a_uart_silent: assert property (link_uart_mode_o |-> !host_link_data_oe_o)
        else $error("host link answered in serial mode");

    c_reply_read: cover property (reply_taken_o);
    c_request_done: cover property (rx_msg_done_o);
    c_clock_stretch: cover property (host_link_clock_oe_o);
    c_self_reset: cover property ($fell(ext_reset_n_oe_o));

endmodule

// ---- verilog/phs_host_side_note.sv ----
// Intentionally empty companion; all logic is in phs_host_side.sv.

// ---- verification/phs_host_master.sv ----
// Host master model for the host link: start, stop and byte tasks.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
module phs_host_master (
    // Link tick and resolved pins
    input wire logic lclk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    // Pull-low enables
    output logic scl_oe_o,
    output logic sda_oe_o
);
    // Half period in link ticks, 400 KHz at 125 ns
    localparam int HALF = 10;

    // Both lines released while idle
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end

    // Wait some link ticks
    task automatic tick(input int n);
        repeat (n) @(posedge lclk_i);
    endtask

    // Release clock, wait out stretching, sample data mid-high
    task automatic clk_high(output logic s);
        scl_oe_o = 1'b0;
        while (scl_i !== 1'b1) @(posedge lclk_i);
        tick(HALF / 2);
        s = sda_i;
        tick(HALF / 2);
    endtask

    // One bit; data moves only well after the clock fall
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        sda_oe_o = ~b;
        tick(HALF - 2);
        clk_high(s);
        scl_oe_o = 1'b1;
    endtask

    task automatic start();
        sda_oe_o = 1'b1;
        tick(HALF);
        scl_oe_o = 1'b1;
    endtask

    task automatic stop();
        logic s;
        tick(2);
        sda_oe_o = 1'b1;
        tick(HALF);
        clk_high(s);
        sda_oe_o = 1'b0;
        tick(HALF);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Last byte is refused with a high acknowledge bit
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask
endmodule

// ---- verification/phs_host_side_tb.sv ----
// Self-checking bench for the host-side signalling block.
// Assumes a 20 MHz system clock and the host master model on the link.
`timescale 1ns/1ps
module phs_host_side_tb
    import phs_pkg::*;
();
    typedef struct {int due; logic [5:0] v;} phs_exp_t;
    logic clk = 1'b0, lclk = 1'b0, rstn = 1'b0, busy = 1'b0, load = 1'b0;
    logic off_n = 1'b1, cool = 1'b0, sel = 1'b0, stb = 1'b0, drv = 1'b0, rreq = 1'b0;
    logic [2:0] sense = 3'h3;
    logic [7:0] ea = 8'h00, ee = 8'h00, hf = 8'h00, hm = 8'h00;
    logic [MSG_W-1:0] rep = '0;
    logic [127:0] w;
    int seed = 92460, bad_count = 0, checks_done = 0, cyc = 0, taken_cnt = 0, str_cnt = 0;
    logic [8:0] rxq[$];
    phs_exp_t sq[$];
    phs_exp_t e;
    logic m_scl_oe, m_sda_oe, clk_oe, dat_oe, uart, rx_valid, rx_done, pend_n, taken;
    logic irq_n, shut, fan, sel_n, stb_n, drv_n, hlt_n, rst_oe, rbusy, lco, ldo, rso;
    logic [6:0] laddr;
    logic [7:0] rx_data;
    wire scl = ~(m_scl_oe | clk_oe);
    wire sda = ~(m_sda_oe | dat_oe);
    wire pin_n = ~rst_oe;

    phs_host_side i_phs_host_side (
        .clk_i(clk), .rstn_i(rstn), .host_link_clock_i(scl), .host_link_clock_o(lco),
        .host_link_clock_oe_o(clk_oe), .host_link_data_i(sda), .host_link_data_o(ldo),
        .host_link_data_oe_o(dat_oe), .link_select_sense_i(sense), .link_uart_mode_o(uart),
        .link_addr_o(laddr), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .rx_msg_done_o(rx_done), .link_busy_i(busy), .reply_msg_i(rep), .reply_load_i(load),
        .reply_pending_n_o(pend_n), .reply_taken_o(taken), .event_active_i(ea),
        .event_enable_i(ee), .event_irq_n_o(irq_n), .all_ports_off_n_i(off_n),
        .ports_shutdown_o(shut), .cool_req_i(cool), .fan_on_o(fan), .ind_select_i(sel),
        .ind_strobe_i(stb), .ind_drive_i(drv), .indicator_select_n_o(sel_n),
        .indicator_strobe_n_o(stb_n), .indicator_drive_en_n_o(drv_n), .health_fault_i(hf),
        .health_mask_i(hm), .health_good_n_o(hlt_n), .self_reset_req_i(rreq),
        .ext_reset_n_i(pin_n), .ext_reset_n_o(rso), .ext_reset_n_oe_o(rst_oe),
        .ext_reset_busy_o(rbusy)
    );

    phs_host_master i_phs_host_master (
        .lclk_i(lclk), .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe)
    );

    // System clock and unrelated link tick
    always #25 clk = ~clk;
    always #62.5 lclk = ~lclk;

    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (!ok) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Write one request; each byte is noted for the watcher
    task automatic send(input logic [6:0] a, input int n, input logic exp_ack);
        logic ack;
        logic [7:0] b;
        i_phs_host_master.start();
        i_phs_host_master.wr_byte({a, 1'b0}, ack);
        check(ack === exp_ack, "address ack");
        for (int k = 0; k < n && ack; k++) begin
            b = 8'($random(seed));
            rxq.push_back({k == 14, b});
            i_phs_host_master.wr_byte(b, ack);
            check(ack === 1'b1, "data ack");
        end
        i_phs_host_master.stop();
    endtask

    // Read n reply bytes, started only while the reply is pending
    task automatic read_reply(input int n);
        logic ack;
        logic [7:0] d;
        if (pend_n === 1'b0) begin
            i_phs_host_master.start();
            i_phs_host_master.wr_byte({7'h23, 1'b1}, ack);
            check(ack === 1'b1, "read address ack");
            for (int k = 0; k < n; k++) begin
                i_phs_host_master.rd_byte(k == n - 1, d);
                check(d === rep[119 - 8 * k -: 8], "reply byte");
            end
            i_phs_host_master.stop();
        end else begin
            check(1'b0, "reply not pending");
        end
    endtask

    // Cycle count, timeout, random busy, stretch and taken counts
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            report_and_stop();
        end
        if (($random(seed) & 63) == 0) busy <= ~busy;
        if (clk_oe === 1'b1) str_cnt <= str_cnt + 1;
        if (taken === 1'b1) taken_cnt <= taken_cnt + 1;
    end

    // Watcher: received bytes and side-band outputs against the notes
    always @(negedge clk) begin
        if (rx_valid === 1'b1) begin
            if (rxq.size() == 0) check(1'b0, "unexpected byte");
            else check({rx_done, rx_data} === rxq.pop_front(), "rx byte");
        end
        if (sq.size() > 0 && cyc >= sq[0].due) begin
            e = sq.pop_front();
            check({irq_n, fan, sel_n, stb_n, drv_n, hlt_n} === e.v, "side-band");
        end
    end

    // Main sequence
    initial begin
        int n;
        repeat (10) @(posedge clk);
        check(pend_n === 1'b1 && shut === 1'b0 && rst_oe === 1'b0, "reset values");
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        check(laddr === 7'h23 && uart === 1'b0, "strap address");
        check({lco, ldo, rso} === 3'h0, "pin drive level");
        repeat (40) begin
            @(posedge clk);
            w = {$random(seed), $random(seed)};
            ea <= w[7:0];
            ee <= w[15:8] & {8{w[40]}};
            hf <= w[23:16];
            hm <= w[31:24] & {8{w[41]}};
            {cool, sel, stb, drv} <= w[35:32];
            sq.push_back(phs_exp_t'{cyc + 2, {~|(w[7:0] & w[15:8] & {8{w[40]}}), w[35],
                ~w[34:32], |(w[23:16] & w[31:24] & {8{w[41]}})}});
        end
        repeat (3) @(posedge clk);
        off_n <= 1'b0;
        repeat (3) @(negedge clk);
        check(shut === 1'b0, "shutdown early");
        @(negedge clk);
        check(shut === 1'b1, "shutdown late");
        @(posedge clk);
        off_n <= 1'b1;
        send(7'h23, 16, 1'b1);
        check(str_cnt > 0, "no stretch");
        send(7'h24, 1, 1'b0);
        @(posedge clk);
        w = {$random(seed), $random(seed), $random(seed), $random(seed)};
        rep <= w[119:0];
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        @(negedge clk);
        check(pend_n === 1'b0, "pending after load");
        read_reply(14);
        check(pend_n === 1'b0 && taken_cnt == 0, "partial read");
        read_reply(15);
        repeat (4) @(negedge clk);
        check(pend_n === 1'b1 && taken_cnt == 1, "pending after read");
        @(posedge clk);
        rreq <= 1'b1;
        @(posedge clk);
        rreq <= 1'b0;
        n = 0;
        @(negedge clk);
        while (rst_oe === 1'b1 && n < 3000) begin
            n++;
            @(negedge clk);
        end
        check(n == SELF_RST_CYC, "self reset length");
        repeat (6) @(negedge clk);
        check(rbusy === 1'b0, "self reset busy");
        @(posedge clk);
        sense <= 3'h0;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        check(uart === 1'b1 && laddr === 7'h20, "serial strap");
        send(7'h20, 1, 1'b0);
        report_and_stop();
    end
endmodule
